// [core/bprc_map.svh]
// Constants of the board power, reset and clock generator controller
`ifndef BPRC_MAP_SVH
`define BPRC_MAP_SVH
`define BPRC_CLK_MHZ 100
`define BPRC_T_AUX_US 10000
`define BPRC_T_STEP_US 5000
`define BPRC_T_WARM_US 5000
`define BPRC_SPI_HALF 5
`define BPRC_SPI_BITS 32
`define BPRC_INIT_WORD0 32'h0000_0000
`define BPRC_INIT_WORD1 32'h0000_0000
`define BPRC_TMR_W 24
`define BPRC_IN_W 13
`define BPRC_IN_IDLE 13'h1807
`define BPRC_IN_COLD 0
`define BPRC_IN_WARM 1
`define BPRC_IN_INSERT 2
`define BPRC_IN_G5V 3
`define BPRC_IN_G2V5 4
`define BPRC_IN_G3V3 5
`define BPRC_IN_G0V75 6
`define BPRC_IN_G1V5 7
`define BPRC_IN_G1V8 8
`define BPRC_IN_RSTAT 9
`define BPRC_IN_BOOT 10
`define BPRC_IN_MISO0 11
`define BPRC_IN_MISO1 12
`endif

// [core/bprc_pkg.sv]
// Types of the board power, reset and clock generator controller
package bprc_pkg;
    typedef enum logic [3:0] {
        S_OFF = 4'h0,
        S_WAIT_AUX = 4'h1,
        S_RAIL_A = 4'h2,
        S_RAIL_18 = 4'h3,
        S_CLK_INIT = 4'h4,
        S_WAIT_15 = 4'h5,
        S_RAIL_075 = 4'h6,
        S_REL_RST = 4'h7,
        S_REL_POR = 4'h8,
        S_REL_FULL = 4'h9,
        S_RUN = 4'hA,
        S_WARM = 4'hB,
        S_DOWN = 4'hC
    } bprc_state_t;
endpackage : bprc_pkg

// [core/bprc_spi_master.sv]
// One SPI master lane toward a clock generator
`timescale 1ns/10ps
`include "bprc_map.svh"
module bprc_spi_master #(
    parameter int HALF = `BPRC_SPI_HALF,
    parameter int BITS = `BPRC_SPI_BITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Request
    input wire logic start,
    input wire logic [BITS-1:0] tx_word,
    output logic busy,
    output logic [BITS-1:0] rx_word,
    // Link, miso already synchronised
    input wire logic miso_s,
    output logic cs_n,
    output logic sck,
    output logic mosi
);
    logic [7:0] half_cnt;
    logic [7:0] bits_left;
    logic [BITS-1:0] shreg;
    wire tick = busy && (half_cnt == 8'(HALF - 1));
    wire last_bit = (bits_left == 8'h01);

    always_ff @(posedge clk) begin
        if (reset) begin
            busy <= 1'b0;
            cs_n <= 1'b1;
            sck <= 1'b0;
            mosi <= 1'b0;
            half_cnt <= 8'h00;
            bits_left <= 8'h00;
            shreg <= '0;
            rx_word <= '0;
        end else if (!busy) begin
            half_cnt <= 8'h00;
            if (start) begin
                busy <= 1'b1;
                cs_n <= 1'b0;
                mosi <= tx_word[BITS-1];
                shreg <= {tx_word[BITS-2:0], 1'b0};
                bits_left <= 8'(BITS);
            end
        end else begin
            half_cnt <= tick ? 8'h00 : half_cnt + 8'h01;
            if (tick && !sck) begin
                sck <= 1'b1;
                rx_word <= {rx_word[BITS-2:0], miso_s};
            end else if (tick) begin
                sck <= 1'b0;
                if (last_bit) begin
                    busy <= 1'b0;
                    cs_n <= 1'b1;
                end else begin
                    mosi <= shreg[BITS-1];
                    shreg <= {shreg[BITS-2:0], 1'b0};
                    bits_left <= bits_left - 8'h01;
                end
            end
        end
    end

    // Helper: rising clock edges seen within one frame
    logic [7:0] rise_cnt;
    always_ff @(posedge clk) begin
        if (reset || $fell(cs_n))
            rise_cnt <= 8'h00;
        else if ($rose(sck))
            rise_cnt <= rise_cnt + 8'h01;
    end

    a_quiet_idle: assert property (@(posedge clk) disable iff (reset)
        cs_n |-> !sck && (!$past(cs_n) || $stable(sck)))
        else $error("serial clock moved with chip select high");
    a_data_fall: assert property (@(posedge clk) disable iff (reset)
        (!cs_n && $past(!cs_n) && $changed(mosi)) |-> $fell(sck))
        else $error("data changed away from a falling clock edge");
    a_frame_bits: assert property (@(posedge clk) disable iff (reset)
        $rose(cs_n) |-> rise_cnt == 8'(BITS))
        else $error("frame did not carry the full bit count");
endmodule : bprc_spi_master

// [core/bprc_ctrl.sv]
// Board power sequencing, reset and clock generator control
`timescale 1ns/10ps
`include "bprc_map.svh"
// How it works
// - Names ending in _n are asserted low and released high.
// - The host reset-status level is mirrored to the manager.
// - The host boot-done level is mirrored to the manager.
// - A rising cold request starts the full reset sequence, released in steps.
// - A rising warm request starts a warm reset that ends after a fixed delay.
// - System power good is high only while all six rails report good.
// - Six rail power-good inputs are watched, each high when valid.
// - Separate enables drive the 5V, 2.5V, 1.8V and 0.75V planes.
// - Each SPI transfer opens with a falling chip select edge.
// - Serial data in both directions is sampled on the rising clock.
// - Serial data lines change on the falling clock, the first bit as chip select falls.
// - Each generator has its own chip select, clock and data out.
// - A low power-down output parks its generator, outputs floating.
// - 5V and 2.5V are enabled only after 3.3V held good for 10 ms.
module bprc_ctrl #(
    parameter int T_AUX_CYC = `BPRC_T_AUX_US * `BPRC_CLK_MHZ,
    parameter int T_STEP_CYC = `BPRC_T_STEP_US * `BPRC_CLK_MHZ,
    parameter int T_WARM_CYC = `BPRC_T_WARM_US * `BPRC_CLK_MHZ,
    parameter int SPI_HALF = `BPRC_SPI_HALF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Management controller
    input wire logic mgmt_insert_n,
    input wire logic mgmt_cold_request_n,
    input wire logic mgmt_warm_request_n,
    output logic mgmt_reset_status_n,
    output logic mgmt_boot_done,
    // Host processor
    input wire logic host_reset_status_n,
    input wire logic host_boot_done,
    output logic host_reset_n,
    output logic host_por_n,
    output logic host_reset_full_n,
    // Rails
    input wire logic rail_5v_good,
    input wire logic rail_2v5_good,
    input wire logic rail_3v3_aux_good,
    input wire logic rail_0v75_good,
    input wire logic rail_1v5_good,
    input wire logic rail_1v8_good,
    output logic system_power_good,
    output logic rail_5v_enable,
    output logic rail_2v5_enable,
    output logic rail_1v8_enable,
    output logic rail_0v75_enable,
    // Clock generators
    output logic [1:0] clkgen_spi_cs_n,
    output logic [1:0] clkgen_spi_sck,
    output logic [1:0] clkgen_spi_mosi,
    input wire logic [1:0] clkgen_spi_miso,
    output logic [1:0] clkgen_powerdown_n,
    output logic [63:0] clkgen_rx_word
);
    // Local names for the sequencer states
    localparam bprc_pkg::bprc_state_t S_OFF = bprc_pkg::S_OFF;
    localparam bprc_pkg::bprc_state_t S_WAIT_AUX = bprc_pkg::S_WAIT_AUX;
    localparam bprc_pkg::bprc_state_t S_RAIL_A = bprc_pkg::S_RAIL_A;
    localparam bprc_pkg::bprc_state_t S_RAIL_18 = bprc_pkg::S_RAIL_18;
    localparam bprc_pkg::bprc_state_t S_CLK_INIT = bprc_pkg::S_CLK_INIT;
    localparam bprc_pkg::bprc_state_t S_WAIT_15 = bprc_pkg::S_WAIT_15;
    localparam bprc_pkg::bprc_state_t S_RAIL_075 = bprc_pkg::S_RAIL_075;
    localparam bprc_pkg::bprc_state_t S_REL_RST = bprc_pkg::S_REL_RST;
    localparam bprc_pkg::bprc_state_t S_REL_POR = bprc_pkg::S_REL_POR;
    localparam bprc_pkg::bprc_state_t S_REL_FULL = bprc_pkg::S_REL_FULL;
    localparam bprc_pkg::bprc_state_t S_RUN = bprc_pkg::S_RUN;
    localparam bprc_pkg::bprc_state_t S_WARM = bprc_pkg::S_WARM;
    localparam bprc_pkg::bprc_state_t S_DOWN = bprc_pkg::S_DOWN;

    // Two-flop synchronisers for every pin input
    logic [`BPRC_IN_W-1:0] meta;
    logic [`BPRC_IN_W-1:0] in_s;
    logic [`BPRC_IN_W-1:0] in_d;
    wire [`BPRC_IN_W-1:0] pins = {clkgen_spi_miso, host_boot_done,
        host_reset_status_n, rail_1v8_good, rail_1v5_good, rail_0v75_good,
        rail_3v3_aux_good, rail_2v5_good, rail_5v_good, mgmt_insert_n,
        mgmt_warm_request_n, mgmt_cold_request_n};

    always_ff @(posedge clk) begin
        // Idle pin levels, so no false request edge follows reset
        if (reset) begin
            meta <= `BPRC_IN_IDLE;
            in_s <= `BPRC_IN_IDLE;
            in_d <= `BPRC_IN_IDLE;
        end else begin
            meta <= pins;
            in_s <= meta;
            in_d <= in_s;
        end
    end

    wire inserted = !in_s[`BPRC_IN_INSERT];
    wire cold_rise = in_s[`BPRC_IN_COLD] && !in_d[`BPRC_IN_COLD];
    wire warm_rise = in_s[`BPRC_IN_WARM] && !in_d[`BPRC_IN_WARM];
    wire aux_good = in_s[`BPRC_IN_G3V3];
    wire a_good = in_s[`BPRC_IN_G5V] && in_s[`BPRC_IN_G2V5];
    wire all_good = &in_s[`BPRC_IN_G1V8:`BPRC_IN_G5V];

    // Sequencer
    bprc_pkg::bprc_state_t state;
    bprc_pkg::bprc_state_t next_state;
    logic [`BPRC_TMR_W-1:0] timer;
    logic [1:0] spi_busy;
    logic spi_start;
    logic spi_sent;

    // Hold condition for the timer in each state
    logic hold_ok;
    logic [`BPRC_TMR_W-1:0] target;
    always_comb begin
        hold_ok = 1'b1;
        target = `BPRC_TMR_W'(T_STEP_CYC);
        case (state)
            S_WAIT_AUX: begin
                hold_ok = aux_good;
                target = `BPRC_TMR_W'(T_AUX_CYC);
            end
            S_RAIL_A: hold_ok = a_good;
            S_RAIL_18: hold_ok = in_s[`BPRC_IN_G1V8];
            S_CLK_INIT: hold_ok = spi_sent && (spi_busy == 2'b00);
            S_WAIT_15: hold_ok = in_s[`BPRC_IN_G1V5];
            S_RAIL_075: hold_ok = in_s[`BPRC_IN_G0V75];
            S_WARM: target = `BPRC_TMR_W'(T_WARM_CYC);
            default: hold_ok = 1'b1;
        endcase
    end
    wire timer_done = hold_ok && (timer >= target - `BPRC_TMR_W'(1));
    // All six rails must stay good from S_REL_RST on; removal also counts as a failure
    wire power_fail = !inserted || (state >= S_REL_RST && !all_good);

    always_comb begin
        next_state = state;
        case (state)
            S_OFF: if (inserted && aux_good) next_state = S_WAIT_AUX;
            S_WAIT_AUX: if (timer_done) next_state = S_RAIL_A;
            S_RAIL_A: if (timer_done) next_state = S_RAIL_18;
            S_RAIL_18: if (timer_done) next_state = S_CLK_INIT;
            S_CLK_INIT: if (timer_done) next_state = S_WAIT_15;
            S_WAIT_15: if (timer_done) next_state = S_RAIL_075;
            S_RAIL_075: if (timer_done) next_state = S_REL_RST;
            S_REL_RST: if (timer_done) next_state = S_REL_POR;
            S_REL_POR: if (timer_done) next_state = S_REL_FULL;
            S_REL_FULL: if (timer_done) next_state = S_RUN;
            S_RUN: begin
                if (cold_rise) next_state = S_REL_RST;
                else if (warm_rise) next_state = S_WARM;
            end
            S_WARM: if (timer_done) next_state = S_RUN;
            S_DOWN: if (timer_done) next_state = S_OFF;
            default: next_state = S_OFF;
        endcase
        if (power_fail && state != S_OFF && state != S_DOWN)
            next_state = S_DOWN;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= S_OFF;
            timer <= '0;
        end else begin
            state <= next_state;
            if (next_state != state || !hold_ok)
                timer <= '0;
            else if (!timer_done)
                timer <= timer + `BPRC_TMR_W'(1);
        end
    end

    // One write per generator once its power-down is released
    always_ff @(posedge clk) begin
        if (reset) begin
            spi_start <= 1'b0;
            spi_sent <= 1'b0;
        end else begin
            spi_start <= (state == S_CLK_INIT) && !spi_sent;
            if (state != S_CLK_INIT)
                spi_sent <= 1'b0;
            else if (spi_start)
                spi_sent <= 1'b1;
        end
    end

    wire warm_active = (next_state == S_WARM);
    wire in_release = (next_state >= S_REL_RST) && (next_state <= S_WARM);

    // Registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            mgmt_reset_status_n <= 1'b0;
            mgmt_boot_done <= 1'b0;
            system_power_good <= 1'b0;
            rail_5v_enable <= 1'b0;
            rail_2v5_enable <= 1'b0;
            rail_1v8_enable <= 1'b0;
            rail_0v75_enable <= 1'b0;
            clkgen_powerdown_n <= 2'b00;
            host_reset_n <= 1'b0;
            host_por_n <= 1'b0;
            host_reset_full_n <= 1'b0;
        end else begin
            mgmt_reset_status_n <= in_s[`BPRC_IN_RSTAT];
            mgmt_boot_done <= in_s[`BPRC_IN_BOOT];
            system_power_good <= all_good;
            // Rails drop together once the down wait ends
            if (next_state == S_OFF) begin
                rail_5v_enable <= 1'b0;
                rail_2v5_enable <= 1'b0;
                rail_1v8_enable <= 1'b0;
                rail_0v75_enable <= 1'b0;
            end else begin
                if (next_state == S_RAIL_A) begin
                    rail_5v_enable <= 1'b1;
                    rail_2v5_enable <= 1'b1;
                end
                if (next_state == S_RAIL_18)
                    rail_1v8_enable <= 1'b1;
                if (next_state == S_RAIL_075)
                    rail_0v75_enable <= 1'b1;
            end
            if (next_state == S_DOWN || next_state == S_OFF)
                clkgen_powerdown_n <= 2'b00;
            else if (next_state == S_CLK_INIT)
                clkgen_powerdown_n <= 2'b11;
            host_reset_n <= in_release && !warm_active
                && next_state != S_REL_RST;
            host_por_n <= in_release && next_state != S_REL_RST
                && next_state != S_REL_POR;
            host_reset_full_n <= next_state == S_RUN || warm_active;
        end
    end

    // Two generator lanes
    wire [63:0] init_words = {`BPRC_INIT_WORD1, `BPRC_INIT_WORD0};
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lane
            bprc_spi_master #(
                .HALF(SPI_HALF),
                .BITS(`BPRC_SPI_BITS)
            ) u_spi (
                .clk(clk),
                .reset(reset),
                .start(spi_start),
                .tx_word(init_words[g*32 +: 32]),
                .busy(spi_busy[g]),
                .rx_word(clkgen_rx_word[g*32 +: 32]),
                .miso_s(in_s[`BPRC_IN_MISO0 + g]),
                .cs_n(clkgen_spi_cs_n[g]),
                .sck(clkgen_spi_sck[g]),
                .mosi(clkgen_spi_mosi[g])
            );
        end
    endgenerate

    a_mirror_status: assert property (@(posedge clk) disable iff (reset)
        ##3 mgmt_reset_status_n == $past(host_reset_status_n, 3))
        else $error("reset status not mirrored");
    a_mirror_boot: assert property (@(posedge clk) disable iff (reset)
        ##3 mgmt_boot_done == $past(host_boot_done, 3))
        else $error("boot done not mirrored");
    a_power_good: assert property (@(posedge clk) disable iff (reset)
        system_power_good |-> $past(all_good))
        else $error("power good without all rails good");
    a_rail_order: assert property (@(posedge clk) disable iff (reset)
        $rose(rail_5v_enable) |-> $past(state) == S_WAIT_AUX
        && $past(timer) == `BPRC_TMR_W'(T_AUX_CYC - 1))
        else $error("5V enabled before 3.3V held long enough");
    sequence s_cold_taken;
        state == S_RUN && cold_rise && !power_fail;
    endsequence
    a_cold_full: assert property (@(posedge clk) disable iff (reset)
        s_cold_taken |=> !host_reset_full_n && !host_por_n)
        else $error("cold request did not start full reset");
    a_warm_only: assert property (@(posedge clk) disable iff (reset)
        (state == S_RUN && warm_rise && !cold_rise && !power_fail)
        |=> !host_reset_n && host_por_n && host_reset_full_n)
        else $error("warm request mishandled");
    a_sync_edge: assert property (@(posedge clk) disable iff (reset)
        cold_rise |-> $past(mgmt_cold_request_n, 2)
        && !$past(mgmt_cold_request_n, 3))
        else $error("edge taken from unsynchronised input");
    a_pd_park: assert property (@(posedge clk) disable iff (reset)
        state == S_DOWN |-> clkgen_powerdown_n == 2'b00)
        else $error("generator left running while powering down");
    a_fail_park: assert property (@(posedge clk) disable iff (reset)
        (power_fail && state != S_OFF && state != S_DOWN) |=> state == S_DOWN
        && !host_por_n && !host_reset_full_n && clkgen_powerdown_n == 2'b00)
        else $error("power failure did not park the host and generators");
    a_warm_end: assert property (@(posedge clk) disable iff (reset)
        (state == S_WARM && timer == `BPRC_TMR_W'(T_WARM_CYC - 1)
        && !power_fail) |=> host_reset_n)
        else $error("warm reset not released after its delay");
    a_insert_gate: assert property (@(posedge clk) disable iff (reset)
        (state == S_OFF && !inserted) |=> state == S_OFF)
        else $error("sequence started without insertion");
endmodule : bprc_ctrl

// [bench/bprc_clkgen_model.sv]
// Clock generator serial slave model
`timescale 1ns/10ps
module bprc_clkgen_model #(
    parameter logic [31:0] REPLY = 32'h5A3C_96E1
) (
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Word written by the master
    output logic [31:0] got
);
    logic [31:0] sh;
    initial begin
        sh = 32'h0000_0000;
        got = 32'h0000_0000;
    end
    // Pulled high while deselected, as on the board
    assign miso = cs_n ? 1'b1 : sh[31];
    always @(negedge cs_n) begin
        sh = REPLY;
        got = 32'h0000_0000;
    end
    always @(posedge sck) if (!cs_n) got <= {got[30:0], mosi};
    always @(negedge sck) if (!cs_n) sh <= {sh[30:0], 1'b0};
endmodule : bprc_clkgen_model

// [bench/board_power_reset_clockgen_ctrl_tb.sv]
// Self-checking bench of the power, reset and clock generator controller
`timescale 1ns/10ps
`include "bprc_map.svh"
module board_power_reset_clockgen_ctrl_tb;
    logic clk = 0, reset = 1, ok = 1, aux = 0;
    logic mgmt_insert_n = 1, mgmt_cold_request_n = 1, mgmt_warm_request_n = 1;
    logic host_reset_status_n = 0, host_boot_done = 0;
    logic rail_5v_good = 0, rail_2v5_good = 0, rail_3v3_aux_good = 0;
    logic rail_0v75_good = 0, rail_1v5_good = 0, rail_1v8_good = 0;
    logic mgmt_reset_status_n, mgmt_boot_done, host_reset_n, host_por_n;
    logic host_reset_full_n, system_power_good, rail_5v_enable;
    logic rail_2v5_enable, rail_1v8_enable, rail_0v75_enable;
    logic [1:0] cs_n, sck, mosi, miso, pd_n, p_cs, p_sck, p_mosi;
    logic [63:0] rx;
    logic [31:0] got0, got1;
    logic [11:0] obs;
    int n_fail = 0, n_checks = 0, rises[2] = '{0, 0};
    always #5 clk = ~clk;
    assign obs = {pd_n, cs_n, system_power_good, host_reset_full_n,
        host_por_n, host_reset_n, rail_0v75_enable, rail_1v8_enable,
        rail_2v5_enable, rail_5v_enable};
    bprc_ctrl #(.T_AUX_CYC(20), .T_STEP_CYC(20), .T_WARM_CYC(20))
        i_dut (.clk(clk), .reset(reset),
        .mgmt_insert_n(mgmt_insert_n),
        .mgmt_cold_request_n(mgmt_cold_request_n),
        .mgmt_warm_request_n(mgmt_warm_request_n),
        .mgmt_reset_status_n(mgmt_reset_status_n),
        .mgmt_boot_done(mgmt_boot_done),
        .host_reset_status_n(host_reset_status_n),
        .host_boot_done(host_boot_done), .host_reset_n(host_reset_n),
        .host_por_n(host_por_n), .host_reset_full_n(host_reset_full_n),
        .rail_5v_good(rail_5v_good), .rail_2v5_good(rail_2v5_good),
        .rail_3v3_aux_good(rail_3v3_aux_good),
        .rail_0v75_good(rail_0v75_good), .rail_1v5_good(rail_1v5_good),
        .rail_1v8_good(rail_1v8_good),
        .system_power_good(system_power_good),
        .rail_5v_enable(rail_5v_enable), .rail_2v5_enable(rail_2v5_enable),
        .rail_1v8_enable(rail_1v8_enable),
        .rail_0v75_enable(rail_0v75_enable), .clkgen_spi_cs_n(cs_n),
        .clkgen_spi_sck(sck), .clkgen_spi_mosi(mosi),
        .clkgen_spi_miso(miso), .clkgen_powerdown_n(pd_n),
        .clkgen_rx_word(rx));
    bprc_clkgen_model #(.REPLY(32'h5A3C_96E1)) i_gen0 (.cs_n(cs_n[0]),
        .sck(sck[0]), .mosi(mosi[0]), .miso(miso[0]), .got(got0));
    bprc_clkgen_model #(.REPLY(32'hC3A5_1E78)) i_gen1 (.cs_n(cs_n[1]),
        .sck(sck[1]), .mosi(mosi[1]), .miso(miso[1]), .got(got1));
    // Supplies come good on the falling clock edge after their enable
    always @(negedge clk) begin
        rail_3v3_aux_good <= aux;
        rail_5v_good <= rail_5v_enable & ok;
        rail_2v5_good <= rail_2v5_enable & ok;
        rail_1v8_good <= rail_1v8_enable & ok;
        rail_1v5_good <= rail_1v8_enable & ok;
        rail_0v75_good <= rail_0v75_enable & ok;
    end
    // Link watcher
    always @(negedge clk) begin
        if (!reset) for (int g = 0; g < 2; g++) begin
            if (!cs_n[g] && !p_sck[g] && sck[g]) rises[g]++;
            if (p_mosi[g] !== mosi[g] && !(p_sck[g] && !sck[g])
                && p_cs[g] === cs_n[g]) chk("mosi_edge", p_mosi[g], mosi[g]);
            if (p_cs[g] && cs_n[g] && p_sck[g] !== sck[g])
                chk("sck_idle", p_sck[g], sck[g]);
        end
        p_cs <= cs_n;
        p_sck <= sck;
        p_mosi <= mosi;
    end
    task automatic chk(input string what, input logic [63:0] exp, got);
        n_checks++;
        if (exp !== got) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_on(input int b, input logic v, input int lim,
        input string what);
        int i;
        i = 0;
        while (obs[b] !== v && i < lim) begin
            @(negedge clk);
            i++;
        end
        chk(what, v, obs[b]);
    endtask : wait_on
    task automatic t_mirror;
        @(negedge clk);
        host_reset_status_n = 1;
        host_boot_done = 1;
        repeat (4) @(negedge clk);
        chk("reset_status", 1, mgmt_reset_status_n);
        chk("boot_done", 1, mgmt_boot_done);
        chk("idle_outputs", 12'h300, obs);
    endtask : t_mirror
    task automatic t_power_up;
        aux = 1;
        repeat (40) @(negedge clk);
        chk("not_inserted", 0, rail_5v_enable);
        mgmt_insert_n = 0;
        repeat (20) @(negedge clk);
        chk("aux_hold", 0, rail_5v_enable);
        wait_on(0, 1, 60, "en_5v");
        chk("en_2v5", 1, rail_2v5_enable);
        wait_on(2, 1, 200, "en_1v8");
        wait_on(8, 0, 200, "cs_fall");
        chk("pd_up", 2'b11, pd_n);
        chk("cs_both", 2'b00, cs_n);
        chk("sck_low", 2'b00, sck);
        wait_on(8, 1, 400, "cs_rise");
        chk("rises0", 32, rises[0]);
        chk("rises1", 32, rises[1]);
        chk("word0", `BPRC_INIT_WORD0, got0);
        chk("word1", `BPRC_INIT_WORD1, got1);
        chk("rx", 64'hC3A5_1E78_5A3C_96E1, rx);
        wait_on(3, 1, 300, "en_0v75");
        wait_on(4, 1, 200, "reset_up");
        chk("por_held", 0, host_por_n);
        wait_on(5, 1, 100, "por_up");
        chk("full_held", 0, host_reset_full_n);
        wait_on(6, 1, 100, "full_up");
        chk("sys_good", 1, system_power_good);
    endtask : t_power_up
    task automatic t_cold;
        mgmt_cold_request_n = 0;
        repeat (6) @(negedge clk);
        chk("fall_ignored", 1, host_reset_n);
        mgmt_cold_request_n = 1;
        wait_on(4, 0, 10, "cold_reset");
        chk("cold_por", 0, host_por_n);
        chk("cold_full", 0, host_reset_full_n);
        wait_on(4, 1, 60, "cold_reset_up");
        chk("cold_por_held", 0, host_por_n);
        wait_on(6, 1, 150, "cold_done");
    endtask : t_cold
    task automatic t_warm;
        int i;
        mgmt_warm_request_n = 0;
        repeat (6) @(negedge clk);
        mgmt_warm_request_n = 1;
        wait_on(4, 0, 10, "warm_reset");
        chk("warm_por", 1, host_por_n);
        i = 1;
        while (obs[4] === 1'b0 && i < 100) begin
            @(negedge clk);
            if (obs[4] === 1'b0) i++;
        end
        chk("warm_width", 20, i);
    endtask : t_warm
    task automatic t_rail_fail;
        ok = 0;
        wait_on(7, 0, 10, "sys_drop");
        chk("fail_reset", 0, host_por_n);
        wait_on(10, 0, 10, "pd_down");
        wait_on(0, 0, 40, "rails_off");
        chk("rails_all", 4'h0, obs[3:0]);
    endtask : t_rail_fail
    task automatic wrap_up;
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (4) @(negedge clk);
        reset = 0;
        t_mirror();
        t_power_up();
        t_cold();
        t_warm();
        t_rail_fail();
        wrap_up();
    end
endmodule : board_power_reset_clockgen_ctrl_tb
